// ==== include/gwd_map.svh ====
// gwd_map.svh: addresses, reset values, field positions and timing counts of the watchdog.
// assumes: included by its bare name from the package only; the design modules use its macros from there.
`ifndef GWD_MAP_SVH
`define GWD_MAP_SVH

// host byte addresses and engine word addresses
`define GWD_LIMIT_LO_ADDR 16'hF126
`define GWD_LIMIT_HI_ADDR 16'hF127
`define GWD_LIMIT_WORD_ADDR 16'h0E93
`define GWD_COUNT_LO_ADDR 16'hF258
`define GWD_COUNT_HI_ADDR 16'hF259
`define GWD_COUNT_WORD_ADDR 16'h0F2C

// reset values
`define GWD_LIMIT_RESET 16'hFFFE
`define GWD_COUNT_RESET 16'h0000
`define GWD_RDATA_RESET 16'h0000

// byte fields inside a 16-bit register
`define GWD_LO_LSB 0
`define GWD_HI_LSB 8
`define GWD_BYTE_W 8

// timing: clock period, oscillator period, divider, reset pulse length
`define GWD_CLK_PERIOD_NS 4
`define GWD_OSC_PERIOD_NS 1000
`define GWD_OSC_CYCLES (`GWD_OSC_PERIOD_NS / `GWD_CLK_PERIOD_NS)
`define GWD_TICK_DIV 16
`define GWD_RST_PULSE_CYCLES 16

`endif

// ==== include/gwd_pkg.sv ====
// gwd_pkg: types shared by the watchdog design files.
// assumes: gwd_map.svh is on the include path.
`include "gwd_map.svh"

package gwd_pkg;

  typedef logic [15:0] gwd_word_t;

  // access handshake states, one-hot
  typedef enum logic [3:0] {
    GWD_IDLE   = 4'h1,
    GWD_SETTLE = 4'h2,
    GWD_EXEC   = 4'h4,
    GWD_DONE   = 4'h8
  } gwd_state_t;

  // register select, one bit per byte lane
  typedef struct packed {
    logic lim_lo;
    logic lim_hi;
    logic cnt_lo;
    logic cnt_hi;
  } gwd_sel_t;

endpackage : gwd_pkg

// ==== rtl/gwd_sync.sv ====
// gwd_sync: two-flop synchroniser for inputs from outside the clock domain.
// assumes: each bit is an independent level; buses are held stable by the sender.
`timescale 1ns/1ps
`default_nettype none

module gwd_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule : gwd_sync

`default_nettype wire

// ==== rtl/gwd_tick.sv ====
// gwd_tick: stands in for the free-running oscillator and its divide-by-16 stage.
// assumes: clk is the watchdog's own always-running clock, never gated.
`timescale 1ns/1ps
`default_nettype none

module gwd_tick (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // one-cycle pulse per counter increment
  output logic tick
);

  logic [7:0] osc_q;
  logic [7:0] osc_d;
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    osc_d = osc_q + 8'h01;
    div_d = div_q;
    tick_d = 1'b0;
    // one oscillator period elapsed
    if (osc_q == 8'(`GWD_OSC_CYCLES - 1)) begin
      osc_d = 8'h00;
      div_d = div_q + 4'h1;
      if (div_q == 4'(`GWD_TICK_DIV - 1)) begin
        div_d = 4'h0;
        tick_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= 8'h00;
      div_q <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      osc_q <= osc_d;
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : gwd_tick

`default_nettype wire

// ==== rtl/gwd_top.sv ====
// gwd_top: watchdog timer with its limit and count registers and chip reset output.
// assumes: clk is the watchdog's own oscillator-derived clock that keeps running when the
// processor clock stops; register accesses arrive asynchronously by a four-phase handshake.
`timescale 1ns/1ps
`default_nettype none

// Function
// - reset chip when count reaches limit
// - count oscillator ticks divided by sixteen
// - keep counting without the main clock
// - timeout restores limit and count power-on values
// - limit read or write clears count
// - reset limit 0xFFFE, enabled at start
// - high-byte limit read restarts counter
// - limit write stores limit, clears count, except in a timeout cycle
// - zero limit disables timeout reset
// - debug mode holds watchdog disabled
// - limit at byte pair and word address
// - count readable at byte pair, word
module gwd_top
  import gwd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register access handshake from the processor or motion engine
  input wire logic acc_req,
  input wire logic acc_wr,
  input wire logic acc_word,
  input wire logic [15:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  output logic acc_ack,
  output logic [15:0] acc_rdata,
  // debug port state
  input wire logic dbg_active,
  // status and reset
  output logic wdt_running,
  output logic chip_rst
);

  // reset release through two flops
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // every asynchronous input passes two flops
  logic [35:0] in_raw;
  logic [35:0] in_s;
  logic req_s;
  logic wr_s;
  logic word_s;
  logic [15:0] addr_s;
  logic [15:0] wdata_s;
  logic dbg_s;

  assign in_raw = {acc_req, acc_wr, acc_word, acc_addr, acc_wdata, dbg_active};

  gwd_sync #(
    .WIDTH(36)
  ) gwd_sync_inst (
    .clk(clk),
    .rst_n(rst_n_q),
    .din(in_raw),
    .dout(in_s)
  );

  assign req_s = in_s[35];
  assign wr_s = in_s[34];
  assign word_s = in_s[33];
  assign addr_s = in_s[32:17];
  assign wdata_s = in_s[16:1];
  assign dbg_s = in_s[0];

  // counter time base
  logic tick;

  gwd_tick gwd_tick_inst (
    .clk(clk),
    .rst_n(rst_n_q),
    .tick(tick)
  );

  // address decode, shared by read and write paths
  function automatic gwd_sel_t gwd_decode(input logic word, input logic [15:0] addr);
    gwd_sel_t sel;
    sel = '0;
    if (word && addr == `GWD_LIMIT_WORD_ADDR) begin
      sel.lim_lo = 1'b1;
      sel.lim_hi = 1'b1;
    end else if (word && addr == `GWD_COUNT_WORD_ADDR) begin
      sel.cnt_lo = 1'b1;
      sel.cnt_hi = 1'b1;
    end else if (!word && addr == `GWD_LIMIT_LO_ADDR) begin
      sel.lim_lo = 1'b1;
    end else if (!word && addr == `GWD_LIMIT_HI_ADDR) begin
      sel.lim_hi = 1'b1;
    end else if (!word && addr == `GWD_COUNT_LO_ADDR) begin
      sel.cnt_lo = 1'b1;
    end else if (!word && addr == `GWD_COUNT_HI_ADDR) begin
      sel.cnt_hi = 1'b1;
    end
    return sel;
  endfunction : gwd_decode

  // access handshake state
  gwd_state_t state_q;
  gwd_state_t state_d;
  logic ack_q;
  logic ack_d;
  gwd_word_t rdata_q;
  gwd_word_t rdata_d;
  logic exec;

  // command snapshot taken in the settle state
  logic cmd_wr_q;
  logic cmd_wr_d;
  logic cmd_word_q;
  logic cmd_word_d;
  gwd_word_t cmd_addr_q;
  gwd_word_t cmd_addr_d;
  gwd_word_t cmd_wdata_q;
  gwd_word_t cmd_wdata_d;

  // watchdog state
  gwd_word_t limit_q;
  gwd_word_t limit_d;
  gwd_word_t count_q;
  gwd_word_t count_d;
  logic [4:0] rst_cnt_q;
  logic [4:0] rst_cnt_d;
  logic chip_rst_q;
  logic chip_rst_d;
  logic running_q;
  logic running_d;

  gwd_sel_t sel;
  logic restart;
  logic lim_wr;
  gwd_word_t lim_new;
  logic enabled;
  logic timeout;

  assign exec = (state_q == GWD_EXEC);
  assign sel = gwd_decode(cmd_word_q, cmd_addr_q);

  // one extra settle cycle: address and data are captured a cycle after the request is seen
  always_comb begin
    state_d = state_q;
    ack_d = ack_q;
    rdata_d = rdata_q;
    case (state_q)
      GWD_IDLE: begin
        if (req_s) begin
          state_d = GWD_SETTLE;
        end
      end
      GWD_SETTLE: begin
        state_d = GWD_EXEC;
      end
      GWD_EXEC: begin
        rdata_d = `GWD_RDATA_RESET;
        if (!cmd_wr_q) begin
          if (cmd_word_q) begin
            if (sel.lim_lo) begin
              rdata_d = limit_q;
            end else if (sel.cnt_lo) begin
              rdata_d = count_q;
            end
          end else begin
            if (sel.lim_lo) begin
              rdata_d = {8'h00, limit_q[`GWD_LO_LSB +: `GWD_BYTE_W]};
            end else if (sel.lim_hi) begin
              rdata_d = {8'h00, limit_q[`GWD_HI_LSB +: `GWD_BYTE_W]};
            end else if (sel.cnt_lo) begin
              rdata_d = {8'h00, count_q[`GWD_LO_LSB +: `GWD_BYTE_W]};
            end else if (sel.cnt_hi) begin
              rdata_d = {8'h00, count_q[`GWD_HI_LSB +: `GWD_BYTE_W]};
            end
          end
        end
        ack_d = 1'b1;
        state_d = GWD_DONE;
      end
      GWD_DONE: begin
        // four-phase: drop ack once the request has gone
        if (!req_s) begin
          ack_d = 1'b0;
          state_d = GWD_IDLE;
        end
      end
      default: begin
        state_d = GWD_IDLE;
        ack_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= GWD_IDLE;
      ack_q <= 1'b0;
      rdata_q <= `GWD_RDATA_RESET;
    end else begin
      state_q <= state_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // a sender that moves the bus early cannot split one access across two decodes
  always_comb begin
    cmd_wr_d = cmd_wr_q;
    cmd_word_d = cmd_word_q;
    cmd_addr_d = cmd_addr_q;
    cmd_wdata_d = cmd_wdata_q;
    if (state_q == GWD_SETTLE) begin
      cmd_wr_d = wr_s;
      cmd_word_d = word_s;
      cmd_addr_d = addr_s;
      cmd_wdata_d = wdata_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_wr_q <= 1'b0;
      cmd_word_q <= 1'b0;
      cmd_addr_q <= 16'h0000;
      cmd_wdata_q <= 16'h0000;
    end else begin
      cmd_wr_q <= cmd_wr_d;
      cmd_word_q <= cmd_word_d;
      cmd_addr_q <= cmd_addr_d;
      cmd_wdata_q <= cmd_wdata_d;
    end
  end

  // merge written bytes into the limit
  always_comb begin
    lim_new = limit_q;
    if (cmd_word_q) begin
      lim_new = cmd_wdata_q;
    end else if (sel.lim_lo) begin
      lim_new[`GWD_LO_LSB +: `GWD_BYTE_W] = cmd_wdata_q[7:0];
    end else if (sel.lim_hi) begin
      lim_new[`GWD_HI_LSB +: `GWD_BYTE_W] = cmd_wdata_q[7:0];
    end
  end

  // any touch of either limit byte restarts; count register reads do not
  assign restart = exec && (sel.lim_lo || sel.lim_hi);
  assign lim_wr = restart && cmd_wr_q;
  assign enabled = (limit_q != 16'h0000) && !dbg_s;
  assign timeout = enabled && (count_q == limit_q) && !chip_rst_q;

  always_comb begin
    limit_d = limit_q;
    count_d = count_q;
    rst_cnt_d = rst_cnt_q;
    chip_rst_d = chip_rst_q;
    running_d = enabled;
    if (timeout) begin
      // the timeout returns the limit and count to power-on values too
      limit_d = `GWD_LIMIT_RESET;
      count_d = `GWD_COUNT_RESET;
      rst_cnt_d = 5'(`GWD_RST_PULSE_CYCLES - 1);
      chip_rst_d = 1'b1;
    end else begin
      if (chip_rst_q) begin
        if (rst_cnt_q == 5'h00) begin
          chip_rst_d = 1'b0;
        end else begin
          rst_cnt_d = rst_cnt_q - 5'h01;
        end
      end
      if (lim_wr) begin
        limit_d = lim_new;
      end
      if (restart || !enabled || chip_rst_q) begin
        count_d = `GWD_COUNT_RESET;
      end else if (tick) begin
        count_d = count_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      limit_q <= `GWD_LIMIT_RESET;
      count_q <= `GWD_COUNT_RESET;
      rst_cnt_q <= 5'h00;
      chip_rst_q <= 1'b0;
      running_q <= 1'b0;
    end else begin
      limit_q <= limit_d;
      count_q <= count_d;
      rst_cnt_q <= rst_cnt_d;
      chip_rst_q <= chip_rst_d;
      running_q <= running_d;
    end
  end

  assign acc_ack = ack_q;
  assign acc_rdata = rdata_q;
  assign wdt_running = running_q;
  assign chip_rst = chip_rst_q;

endmodule : gwd_top

`default_nettype wire

// ==== test/gwd_top_asserts.sv ====
// gwd_top_asserts: port timing checks for the watchdog.
// assumes: bound to gwd_top, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module gwd_top_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // access
  input wire logic acc_req,
  input wire logic acc_wr,
  input wire logic acc_word,
  input wire logic [15:0] acc_addr,
  input wire logic [15:0] acc_wdata,
  input wire logic acc_ack,
  input wire logic [15:0] acc_rdata,
  // status
  input wire logic dbg_active,
  input wire logic wdt_running,
  input wire logic chip_rst
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // cycles the reset pulse has stood so far
  logic [4:0] hi_q, hi_d;
  always_comb hi_d = chip_rst ? hi_q + 5'h01 : 5'h00;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) hi_q <= 5'h00;
    else hi_q <= hi_d;
  end
  sequence s_busy;
    (!acc_ack)[*4];
  endsequence
  sequence s_answer;
    ##[1:2] acc_ack;
  endsequence
  a_ack_timing: assert property ($rose(acc_req) |-> s_busy ##0 s_answer)
    else $error("ack timing");
  a_ack_hold: assert property (acc_ack && acc_req |=> acc_ack)
    else $error("ack dropped");
  a_ack_release: assert property ($fell(acc_req) |-> ##[1:5] !acc_ack)
    else $error("ack stuck");
  a_ack_cause: assert property ($rose(acc_ack) |-> acc_req && $past(acc_req, 4))
    else $error("ack uncaused");
  a_rdata_steady: assert property (acc_ack && $past(acc_ack) |-> $stable(acc_rdata))
    else $error("rdata moved");
  a_byte_upper: assert property ($rose(acc_ack) && !acc_wr && !acc_word
    |-> acc_rdata[15:8] == 8'h00)
    else $error("byte upper");
  a_rst_len: assert property ($fell(chip_rst) |-> hi_q == 5'h10)
    else $error("pulse length");
  a_rst_max: assert property (hi_q <= 5'h10)
    else $error("pulse long");
  a_rst_enabled: assert property ($rose(chip_rst) |-> $past(wdt_running))
    else $error("reset disabled");
  a_dbg_stop: assert property (dbg_active[*6] |-> !wdt_running)
    else $error("debug running");
endmodule : gwd_top_asserts
`default_nettype wire

// ==== test/gwd_top_tb.sv ====
// gwd_top_tb: self-checking bench for the watchdog.
// assumes: design and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module gwd_top_tb;
  import gwd_pkg::*;
  logic clk = 1'h0, arst_n = 1'h0, acc_req = 1'h0, acc_wr = 1'h0;
  logic acc_word = 1'h0, dbg_active = 1'h0, acc_ack, wdt_running, chip_rst, ack_p = 1'h0;
  gwd_word_t acc_addr = 16'h0000, acc_wdata = 16'h0000, acc_rdata, v, exp_q[$];
  int miscompares = 0, checked = 0, n_rst = 0, n, m;
  integer seed = 32'h4BED;
  always #2 clk = ~clk;
  gwd_top gwd_top_inst (.clk(clk), .arst_n(arst_n), .acc_req(acc_req), .acc_wr(acc_wr),
    .acc_word(acc_word), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ack(acc_ack),
    .acc_rdata(acc_rdata), .dbg_active(dbg_active), .wdt_running(wdt_running),
    .chip_rst(chip_rst));
  always @(posedge chip_rst) n_rst++;
  always @(negedge clk) begin
    if (acc_ack && !ack_p && exp_q.size() > 0) chk(acc_rdata, exp_q.pop_front());
    ack_p <= acc_ack;
  end
  task chk(input gwd_word_t seen, input gwd_word_t exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // data settles a cycle before the request, four-phase handshake
  task acc(input logic wr, input logic wd, input gwd_word_t a, input gwd_word_t d);
    @(negedge clk);
    {acc_wr, acc_word, acc_addr, acc_wdata} = {wr, wd, a, d};
    @(negedge clk);
    acc_req = 1'h1;
    for (int i = 0; i < 20 && acc_ack !== 1'h1; i++) @(negedge clk);
    // request stands through the edge that samples ack high
    @(negedge clk);
    acc_req = 1'h0;
    for (int i = 0; i < 20 && acc_ack !== 1'h0; i++) @(negedge clk);
  endtask : acc
  task rd(input logic wd, input gwd_word_t a, input gwd_word_t e);
    exp_q.push_back(e);
    acc(1'h0, wd, a, 16'h0000);
  endtask : rd
  task results();
    chk(16'(exp_q.size()), 16'h0000);
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (8) @(negedge clk);
    arst_n = 1'h1;
    repeat (4) @(negedge clk);
    chk(16'(wdt_running), 16'h0001);
    rd(1'h1, 16'h0E93, 16'hFFFE);
    rd(1'h1, 16'h0F2C, 16'h0000);
    $display("reset done");
    repeat (3) begin
      v = 16'($random(seed)) | 16'h0100;
      acc(1'h1, 1'h1, 16'h0E93, v);
      rd(1'h0, 16'hF126, {8'h00, v[7:0]});
      rd(1'h0, 16'hF127, {8'h00, v[15:8]});
    end
    acc(1'h1, 1'h1, 16'h0F2C, 16'h1234);
    acc(1'h1, 1'h1, 16'h1234, 16'h0000);
    rd(1'h1, 16'h1234, 16'h0000);
    rd(1'h1, 16'h0E93, v);
    rd(1'h0, 16'hF259, 16'h0000);
    $display("map done");
    acc(1'h1, 1'h0, 16'hF126, 16'h0002);
    acc(1'h1, 1'h0, 16'hF127, 16'h0000);
    rd(1'h1, 16'h0E93, 16'h0002);
    // restarts well inside the shortest timeout keep the chip out of reset
    m = n_rst;
    repeat (3) begin
      repeat (3000) @(negedge clk);
      rd(1'h0, 16'hF127, 16'h0000);
    end
    chk(16'(n_rst - m), 16'h0000);
    $display("restart done");
    n = 0;
    while (chip_rst !== 1'h1 && n < 12000) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n > 3980 && n < 8010), 16'h0001);
    repeat (20) @(negedge clk);
    rd(1'h1, 16'h0E93, 16'hFFFE);
    $display("timeout done");
    acc(1'h1, 1'h1, 16'h0E93, 16'h0000);
    m = n_rst;
    repeat (9000) @(negedge clk);
    chk(16'(wdt_running), 16'h0000);
    chk(16'(n_rst - m), 16'h0000);
    dbg_active = 1'h1;
    acc(1'h1, 1'h1, 16'h0E93, 16'h0002);
    repeat (9000) @(negedge clk);
    chk(16'(wdt_running), 16'h0000);
    chk(16'(n_rst - m), 16'h0000);
    dbg_active = 1'h0;
    $display("disable done");
    results();
  end
  // whole run is near 34000 cycles
  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule : gwd_top_tb
bind gwd_top gwd_top_asserts gwd_top_asserts_inst (.clk(clk), .arst_n(arst_n),
  .acc_req(acc_req), .acc_wr(acc_wr), .acc_word(acc_word), .acc_addr(acc_addr),
  .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
  .dbg_active(dbg_active), .wdt_running(wdt_running), .chip_rst(chip_rst));
`default_nettype wire
